// ### hw/power_mode_controller.sv
// Power mode controller: idle, stop and suspend sequencing, AXI4-Lite regs
`timescale 1ns/1ps
`include "pmc_map.svh"
module power_mode_controller #(
  parameter int ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic insn_done_in,
  input wire logic irq_pending_in,
  input wire logic wdt_timeout_in,
  input wire logic clk_loss_in,
  input wire logic ext_rst_n_in,
  input wire logic port_match_in,
  input wire logic comp_low_in,
  output pmc_pkg::pwr_ctl_t ctl_out,
  output logic wake_irq_out,
  output logic resume_out,
  output logic reset_req_out,
  output logic [15:0] fetch_addr_out
);
  pmc_pkg::st_t s_r;
  pmc_pkg::st_t s_nxt;
  logic [2:0] pins_s;
  logic ext_rst_n_s;
  logic port_match_s;
  logic comp_low_s;
  logic rst_evt;
  logic susp_evt;
  pmc_pkg::reg_idx_t rd_sel;
  logic [7:0] rd_val;

  function automatic pmc_pkg::reg_idx_t dec(input logic [7:0] a);
    unique case (a)
      `OFS_POWER_CTRL: dec = pmc_pkg::IDX_PWR;
      `OFS_OSC_CTRL: dec = pmc_pkg::IDX_OSC;
      `OFS_STATUS: dec = pmc_pkg::IDX_STAT;
      default: dec = pmc_pkg::IDX_NONE;
    endcase
  endfunction

  pmc_sync #(
    .W(3),
    .RST_VAL(`SYNC_RST_VAL)
  ) u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in({comp_low_in, port_match_in, ext_rst_n_in}),
    .sync_out(pins_s)
  );
  assign ext_rst_n_s = pins_s[0];
  assign port_match_s = pins_s[1];
  assign comp_low_s = pins_s[2];

  // Watchdog only counts while timers are clocked, so not in stop/suspend
  assign rst_evt = !ext_rst_n_s || clk_loss_in ||
                   (wdt_timeout_in && s_r.ctl.timer_en);
  assign susp_evt = port_match_s ||
                    (comp_low_s && s_r.comp_wake_en);

  always_comb begin
    rd_sel = dec(8'(araddr_in));
    rd_val = 8'h00;
    unique case (rd_sel)
      pmc_pkg::IDX_PWR: rd_val = {s_r.flags, 2'h0};
      pmc_pkg::IDX_OSC: rd_val[`OSC_COMP_WAKE_BIT] = s_r.comp_wake_en;
      pmc_pkg::IDX_STAT: begin
        rd_val[`STAT_MODE_MSB:`STAT_MODE_LSB] = s_r.mode;
        rd_val[`STAT_CAUSE_MSB:`STAT_CAUSE_LSB] = s_r.cause;
      end
      pmc_pkg::IDX_NONE: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.wake_irq = 1'b0;
    s_nxt.resume = 1'b0;
    s_nxt.reset_req = 1'b0;
    // Read channel
    if (s_r.rvalid && rready_in) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid_in && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rd_idx = rd_sel;
      s_nxt.rdata = rd_val;
      s_nxt.rresp = (rd_sel == pmc_pkg::IDX_NONE) ? `RESP_SLVERR
                                                  : `RESP_OKAY;
    end
    // Write channel: address and data in either order
    if (s_r.bvalid && bready_in) begin
      s_nxt.bvalid = 1'b0;
    end
    if (awvalid_in && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = 8'(awaddr_in);
    end
    if (wvalid_in && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata_in[7:0];
      s_nxt.wbyte = wstrb_in[0];
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `RESP_OKAY;
      unique case (dec(s_r.waddr))
        pmc_pkg::IDX_PWR: begin
          if (s_r.wbyte) begin
            s_nxt.flags = s_r.wdata[7:`PWR_FLAGS_LSB];
            s_nxt.sel_idle = s_r.sel_idle ||
                             s_r.wdata[`PWR_IDLE_BIT];
            s_nxt.sel_stop = s_r.sel_stop ||
                             s_r.wdata[`PWR_STOP_BIT];
          end
        end
        pmc_pkg::IDX_OSC: begin
          if (s_r.wbyte) begin
            s_nxt.comp_wake_en = s_r.wdata[`OSC_COMP_WAKE_BIT];
            s_nxt.sel_susp = s_r.sel_susp ||
                             s_r.wdata[`OSC_SUSPEND_BIT];
          end
        end
        pmc_pkg::IDX_STAT: s_nxt.bresp = `RESP_OKAY;
        pmc_pkg::IDX_NONE: s_nxt.bresp = `RESP_SLVERR;
      endcase
    end
    // Mode sequencing; register contents are never touched by sleep
    unique case (s_r.mode)
      pmc_pkg::MODE_RUN: begin
        if (s_nxt.sel_idle || s_nxt.sel_stop || s_nxt.sel_susp) begin
          s_nxt.mode = pmc_pkg::MODE_PEND;
        end
      end
      pmc_pkg::MODE_PEND: begin
        // Wait for the writing instruction to retire
        if (insn_done_in) begin
          if (s_nxt.sel_stop) begin
            s_nxt.mode = pmc_pkg::MODE_STOP;
          end else if (s_nxt.sel_susp) begin
            s_nxt.mode = pmc_pkg::MODE_SUSP;
          end else begin
            s_nxt.mode = pmc_pkg::MODE_IDLE;
          end
        end
      end
      pmc_pkg::MODE_IDLE: begin
        if (irq_pending_in) begin
          s_nxt.mode = pmc_pkg::MODE_RUN;
          s_nxt.sel_idle = 1'b0;
          s_nxt.wake_irq = 1'b1;
          s_nxt.resume = 1'b1;
          s_nxt.cause = pmc_pkg::WAKE_IRQ;
        end
      end
      pmc_pkg::MODE_STOP: s_nxt.mode = pmc_pkg::MODE_STOP;
      pmc_pkg::MODE_SUSP: begin
        if (susp_evt) begin
          s_nxt.mode = pmc_pkg::MODE_RUN;
          s_nxt.sel_susp = 1'b0;
          s_nxt.sel_idle = 1'b0;
          s_nxt.resume = 1'b1;
          s_nxt.wake_irq = irq_pending_in;
          s_nxt.cause = pmc_pkg::WAKE_EVENT;
        end
      end
    endcase
    // Internal or external reset wins over any wake or entry
    if (rst_evt) begin
      s_nxt.mode = pmc_pkg::MODE_RUN;
      s_nxt.sel_idle = 1'b0;
      s_nxt.sel_stop = 1'b0;
      s_nxt.sel_susp = 1'b0;
      s_nxt.wake_irq = 1'b0;
      s_nxt.resume = 1'b0;
      s_nxt.reset_req = 1'b1;
      s_nxt.fetch_addr = `RESET_VECTOR;
      s_nxt.cause = pmc_pkg::WAKE_RESET;
    end
    // Clock and domain enables follow the next mode
    s_nxt.ctl.cpu_clk_en = (s_nxt.mode == pmc_pkg::MODE_RUN) ||
                           (s_nxt.mode == pmc_pkg::MODE_PEND);
    s_nxt.ctl.periph_clk_en = (s_nxt.mode != pmc_pkg::MODE_STOP) &&
                              (s_nxt.mode != pmc_pkg::MODE_SUSP);
    s_nxt.ctl.irq_logic_en = (s_nxt.mode != pmc_pkg::MODE_STOP);
    s_nxt.ctl.timer_en = s_nxt.ctl.periph_clk_en;
    s_nxt.ctl.osc_en = s_nxt.ctl.periph_clk_en;
    s_nxt.ctl.clk_loss_en = 1'b1;
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
  end

  // Reset clears state and leaves outputs low until the first edge after release
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready_out = s_r.awready;
  assign wready_out = s_r.wready;
  assign bvalid_out = s_r.bvalid;
  assign bresp_out = s_r.bresp;
  assign arready_out = s_r.arready;
  assign rvalid_out = s_r.rvalid;
  assign rresp_out = s_r.rresp;
  assign rdata_out = {24'h000000, s_r.rdata};
  assign ctl_out = s_r.ctl;
  assign wake_irq_out = s_r.wake_irq;
  assign resume_out = s_r.resume;
  assign reset_req_out = s_r.reset_req;
  assign fetch_addr_out = s_r.fetch_addr;

  AST_IDLE_ENTRY: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_PEND && insn_done_in && !rst_evt &&
     !s_r.sel_stop && !s_r.sel_susp) |=> (s_r.mode == pmc_pkg::MODE_IDLE))
    else $error("idle not entered after instruction done");
  AST_PEND_WAIT: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_PEND && !insn_done_in && !rst_evt)
    |=> (s_r.mode == pmc_pkg::MODE_PEND) && s_r.ctl.cpu_clk_en)
    else $error("sleep entered before instruction done");
  AST_IDLE_HOLD: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_IDLE && !irq_pending_in && !rst_evt)
    |=> (s_r.mode == pmc_pkg::MODE_IDLE))
    else $error("idle left without interrupt or reset");
  AST_IDLE_WAKE: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_IDLE && irq_pending_in && !rst_evt)
    |=> (s_r.mode == pmc_pkg::MODE_RUN) && !s_r.sel_idle &&
        s_r.wake_irq && s_r.ctl.cpu_clk_en ##1 !s_r.wake_irq)
    else $error("interrupt wake from idle wrong");
  AST_RESUME_PAIR: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    $rose(s_r.resume) |-> $past(s_r.mode) != pmc_pkg::MODE_RUN &&
                          !s_r.reset_req)
    else $error("resume without prior sleep");
  AST_RESET_WAKE: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (rst_evt && s_r.mode != pmc_pkg::MODE_RUN) |=>
    s_r.reset_req && s_r.fetch_addr == `RESET_VECTOR &&
    s_r.mode == pmc_pkg::MODE_RUN && !s_r.resume)
    else $error("reset did not end sleep at vector");
  AST_WDT_IDLE: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_IDLE && wdt_timeout_in) |=> s_r.reset_req)
    else $error("watchdog timeout ignored in idle");
  AST_STOP_CTL: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_STOP) |-> !s_r.ctl.osc_en &&
    !s_r.ctl.timer_en && !s_r.ctl.irq_logic_en && s_r.ctl.clk_loss_en &&
    !s_r.ctl.cpu_clk_en)
    else $error("stop enables wrong");
  AST_SUSP_WAKE: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_SUSP && susp_evt && !rst_evt) |=>
    s_r.mode == pmc_pkg::MODE_RUN && s_r.resume && s_r.ctl.osc_en)
    else $error("suspend wake missed");
  AST_STOP_HOLD: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_STOP && !rst_evt)
    [*2] |=> s_r.mode == pmc_pkg::MODE_STOP)
    else $error("stop left without reset");
  AST_SEL_READ_ZERO: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.rvalid && s_r.rd_idx == pmc_pkg::IDX_PWR) |->
    s_r.rdata[`PWR_STOP_BIT:`PWR_IDLE_BIT] == 2'h0)
    else $error("select bits read nonzero");
  AST_IDLE_GATE: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (s_r.mode == pmc_pkg::MODE_IDLE) |-> !s_r.ctl.cpu_clk_en &&
    s_r.ctl.periph_clk_en && s_r.ctl.irq_logic_en && s_r.ctl.timer_en)
    else $error("idle clock gating wrong");
endmodule

// ### hw/pmc_map.svh
// Register offsets, field positions and constants of the power controller
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define OFS_POWER_CTRL 8'h00
`define OFS_OSC_CTRL 8'h04
`define OFS_STATUS 8'h08
`define PWR_IDLE_BIT 0
`define PWR_STOP_BIT 1
`define PWR_FLAGS_LSB 2
`define OSC_COMP_WAKE_BIT 0
`define OSC_SUSPEND_BIT 5
`define STAT_MODE_LSB 0
`define STAT_MODE_MSB 2
`define STAT_CAUSE_LSB 4
`define STAT_CAUSE_MSB 5
`define RESET_VECTOR 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SYNC_RST_VAL 3'h1
`endif

// ### hw/pmc_pkg.sv
// Types shared by the power mode controller
package pmc_pkg;
  typedef enum logic [2:0] {
    MODE_RUN, MODE_PEND, MODE_IDLE, MODE_STOP, MODE_SUSP
  } mode_t;
  typedef enum logic [1:0] {
    WAKE_NONE, WAKE_IRQ, WAKE_EVENT, WAKE_RESET
  } cause_t;
  typedef enum logic [1:0] {IDX_PWR, IDX_OSC, IDX_STAT, IDX_NONE} reg_idx_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic irq_logic_en;
    logic timer_en;
    logic osc_en;
    logic clk_loss_en;
  } pwr_ctl_t;
  typedef struct packed {
    mode_t mode;
    cause_t cause;
    logic sel_idle;
    logic sel_stop;
    logic sel_susp;
    logic [5:0] flags;
    logic comp_wake_en;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic wbyte;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    reg_idx_t rd_idx;
    pwr_ctl_t ctl;
    logic wake_irq;
    logic resume;
    logic reset_req;
    logic [15:0] fetch_addr;
  } st_t;
endpackage

// ### hw/pmc_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pmc_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ### tb/core_model.sv
// Processor core and interrupt logic model facing the power controller
`timescale 1ns/1ps
module core_model (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic bvalid_in,
  input wire logic bready_in,
  input wire logic slow_in,
  input wire logic irq_req_in,
  input wire logic wake_irq_in,
  input wire logic reset_req_in,
  output logic insn_done_out,
  output logic irq_pending_out
);
  logic [2:0] cnt_r;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= 3'h0;
      insn_done_out <= 1'h0;
      irq_pending_out <= 1'h0;
    end else begin
      insn_done_out <= 1'h0;
      // One retire per write; follower is multi-byte, no mid-op interrupt
      if (bvalid_in && bready_in) begin
        cnt_r <= slow_in ? 3'h4 : 3'h1;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
        insn_done_out <= (cnt_r == 3'h1);
      end
      // Posted until serviced or wiped by a reset event
      if (irq_req_in) begin
        irq_pending_out <= 1'h1;
      end else if (wake_irq_in || reset_req_in) begin
        irq_pending_out <= 1'h0;
      end
    end
  end
endmodule

// ### tb/power_mode_controller_tb.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
`include "pmc_map.svh"
module power_mode_controller_tb;
  logic clock_in, sys_rst_in, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata_out, d;
  logic [3:0] wstrb;
  logic [1:0] bresp_out, rresp_out, r;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic insn_done, irq_pending, wdt, clk_loss, ext_rst_n, pmatch, comp_low;
  logic slow, irq_req, wake_irq_out, resume_out, reset_req_out;
  logic [15:0] fetch_addr_out;
  pmc_pkg::pwr_ctl_t ctl_out;
  int fails, tests_run, n_wake, n_res, n_rst, w0, r0, q0;

  power_mode_controller dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready_out),
    .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
    .wready_out(wready_out), .bresp_out(bresp_out), .bvalid_out(bvalid_out),
    .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready_out), .rdata_out(rdata_out), .rresp_out(rresp_out),
    .rvalid_out(rvalid_out), .rready_in(rready), .insn_done_in(insn_done),
    .irq_pending_in(irq_pending), .wdt_timeout_in(wdt),
    .clk_loss_in(clk_loss), .ext_rst_n_in(ext_rst_n), .port_match_in(pmatch),
    .comp_low_in(comp_low), .ctl_out(ctl_out), .wake_irq_out(wake_irq_out),
    .resume_out(resume_out), .reset_req_out(reset_req_out),
    .fetch_addr_out(fetch_addr_out));

  core_model core_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .bvalid_in(bvalid_out), .bready_in(bready), .slow_in(slow),
    .irq_req_in(irq_req), .wake_irq_in(wake_irq_out),
    .reset_req_in(reset_req_out), .insn_done_out(insn_done),
    .irq_pending_out(irq_pending));

  initial begin
    clock_in = 1'h0;
    forever #25 clock_in = ~clock_in;
  end

  // Pulse counts prove one-cycle width as well as presence
  always @(posedge clock_in) begin
    if (wake_irq_out === 1'h1) n_wake++;
    if (resume_out === 1'h1) n_res++;
    if (reset_req_out === 1'h1) n_rst++;
  end

  task wrap_up;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task hang;
    fails++;
    $display("[ERR] %0t bus wait ran out", $time);
    wrap_up;
  endtask

  task settle(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clock_in);
      n++;
      if (awready_out === 1'h1) awvalid <= 1'h0;
      if (wready_out === 1'h1) wvalid <= 1'h0;
      if (n > 40) hang();
    end while (bvalid_out !== 1'h1);
    r = bresp_out;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clock_in);
      n++;
      if (arready_out === 1'h1) arvalid <= 1'h0;
      if (n > 40) hang();
    end while (rvalid_out !== 1'h1);
    d = rdata_out;
    r = rresp_out;
    rready <= 1'h0;
  endtask

  // Status word: cause in [5:4], mode in [2:0]
  task st(input logic [2:0] m, input logic [1:0] c);
    rd(`OFS_STATUS);
    chk(d, {26'h0, c, 1'h0, m});
  endtask

  // Bit order: ext pin low, watchdog, clock loss, match, comparator, irq
  task ev(input logic [5:0] v, input int len);
    {ext_rst_n, wdt, clk_loss, pmatch, comp_low, irq_req} <= v ^ 6'h20;
    settle(len);
    {ext_rst_n, wdt, clk_loss, pmatch, comp_low, irq_req} <= 6'h20;
  endtask

  task snap;
    w0 = n_wake;
    r0 = n_res;
    q0 = n_rst;
  endtask

  task rst;
    sys_rst_in <= 1'h1;
    settle(8);
    sys_rst_in <= 1'h0;
    // Run levels appear at the first edge, so look after the second
    settle(2);
  endtask

  task t_regs;
    st(3'h0, 2'h0);
    rd(8'h0C);
    chk(d, 32'h0);
    chk(r, `RESP_SLVERR);
    wr(8'h0C, 32'hFF, 4'hF);
    chk(r, `RESP_SLVERR);
    wr(`OFS_STATUS, 32'hFF, 4'hF);
    chk(r, `RESP_OKAY);
    wr(`OFS_POWER_CTRL, 32'hFC, 4'hF);
    wr(`OFS_POWER_CTRL, 32'h00, 4'h0);
    rd(`OFS_POWER_CTRL);
    chk(d, 32'hFC);
    st(3'h0, 2'h0);
  endtask

  task t_idle;
    slow <= 1'h1;
    snap();
    wr(`OFS_POWER_CTRL, 32'hFD, 4'hF);
    st(3'h1, 2'h0);
    chk(ctl_out, 6'h3F);
    settle(6);
    chk(ctl_out, 6'h1F);
    rd(`OFS_POWER_CTRL);
    chk(d, 32'hFC);
    ev(6'h06, 3);
    settle(6);
    st(3'h2, 2'h0);
    ev(6'h01, 1);
    settle(3);
    chk(ctl_out, 6'h3F);
    chk(n_wake - w0, 32'h1);
    chk(n_res - r0, 32'h1);
    wr(`OFS_POWER_CTRL, 32'hFC, 4'hF);
    settle(6);
    st(3'h0, 2'h1);
    rd(`OFS_POWER_CTRL);
    chk(d, 32'hFC);
    slow <= 1'h0;
  endtask

  task t_stop;
    snap();
    wr(`OFS_POWER_CTRL, 32'h02, 4'hF);
    settle(4);
    chk(ctl_out, 6'h01);
    ev(6'h01, 1);
    settle(6);
    st(3'h3, 2'h1);
    ev(6'h08, 1);
    settle(3);
    chk(n_wake - w0, 32'h0);
    chk(n_rst - q0, 32'h1);
    chk({ctl_out, fetch_addr_out}, {6'h3F, `RESET_VECTOR});
    st(3'h0, 2'h3);
  endtask

  task t_susp;
    snap();
    wr(`OFS_OSC_CTRL, 32'h20, 4'hF);
    settle(4);
    chk({ctl_out.cpu_clk_en, ctl_out.osc_en}, 2'h0);
    ev(6'h02, 2);
    settle(6);
    st(3'h4, 2'h3);
    ev(6'h04, 2);
    settle(6);
    st(3'h0, 2'h2);
    chk(n_wake - w0, 32'h0);
    chk(n_res - r0, 32'h1);
    wr(`OFS_OSC_CTRL, 32'h21, 4'hF);
    rd(`OFS_OSC_CTRL);
    chk(d, 32'h01);
    settle(2);
    ev(6'h03, 2);
    settle(6);
    st(3'h0, 2'h2);
    chk(n_wake - w0, 32'h1);
    chk(n_res - r0, 32'h2);
  endtask

  task t_resets;
    snap();
    wr(`OFS_POWER_CTRL, 32'h01, 4'hF);
    settle(4);
    ev(6'h10, 1);
    settle(3);
    st(3'h0, 2'h3);
    chk(n_rst - q0, 32'h1);
    wr(`OFS_POWER_CTRL, 32'h01, 4'hF);
    settle(4);
    ev(6'h20, 3);
    settle(6);
    st(3'h0, 2'h3);
    // Pin held low for three synchronised cycles adds three requests
    chk(n_rst - q0, 32'h4);
    // Idle and stop both selected: stop must win
    wr(`OFS_POWER_CTRL, 32'hFF, 4'hF);
    settle(4);
    st(3'h3, 2'h3);
    rst();
    chk(ctl_out, 6'h3F);
    st(3'h0, 2'h0);
    rd(`OFS_POWER_CTRL);
    chk(d, 32'h0);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, slow} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {ext_rst_n, wdt, clk_loss, pmatch, comp_low, irq_req} = 6'h20;
    {fails, tests_run, n_wake, n_res, n_rst} = '0;
    sys_rst_in = 1'h1;
    rst();
    t_regs();
    t_idle();
    t_stop();
    t_susp();
    t_resets();
    wrap_up();
  end
endmodule
